// >>> core/i2cew_buf2.sv
// two-entry buffer between received data bytes and the memory port
`timescale 1ns/100ps
`include "i2cew_map.svh"
module i2cew_buf2 #(
    parameter int WIDTH = 26
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] head_q, head_d, tail_q, tail_d;
    logic [1:0] cnt_q, cnt_d;
    logic valid_q, valid_d;
    logic push, pop;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("i2cew_buf2: WIDTH must be positive");
        end
    endgenerate

    // =================================================================
    // next state
    always_comb begin
        in_ready = (cnt_q != 2'h2);
        push = in_valid && in_ready;
        pop = valid_q && out_ready;
        head_d = head_q;
        tail_d = tail_q;
        cnt_d = cnt_q;
        unique case ({push, pop})
            2'b10: begin
                if (cnt_q == 2'h0) begin
                    head_d = in_data;
                end else begin
                    tail_d = in_data;
                end
                cnt_d = cnt_q + 2'h1;
            end
            2'b01: begin
                head_d = tail_q;
                cnt_d = cnt_q - 2'h1;
            end
            2'b11: begin
                if (cnt_q == 2'h1) begin
                    head_d = in_data;
                end else begin
                    head_d = tail_q;
                    tail_d = in_data;
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
        valid_d = (cnt_d != 2'h0);
    end

    // =================================================================
    // registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q <= 2'h0;
            valid_q <= 1'h0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
        end
    end

    assign out_data = head_q;
    assign out_valid = valid_q;
endmodule

// >>> core/i2cew_map.svh
// constants for the two-wire write-path slave
`ifndef I2CEW_MAP_SVH
`define I2CEW_MAP_SVH

// =====================================================================
// select code layout
`define I2CEW_TYPE_MSB 7
`define I2CEW_TYPE_LSB 5
`define I2CEW_TYPE_HEAD 3'h5
`define I2CEW_SEL_IDPAGE 4
`define I2CEW_SEL_STRAP_HI 3
`define I2CEW_SEL_STRAP_LO 2
`define I2CEW_SEL_TOP_ADDR 1
`define I2CEW_SEL_DIR 0
`define I2CEW_DIR_READ 1'h1

// =====================================================================
// address and lock fields
`define I2CEW_LOCK_SEL_BIT 10
`define I2CEW_LOCK_DATA_BIT 1
`define I2CEW_ADDR_RESET 17'h00000

// =====================================================================
// bit slots and timing
`define I2CEW_ACK_SLOT 4'h8
`define I2CEW_BIT_RESET 4'h0
`define I2CEW_CLK_KHZ 25000
`define I2CEW_WRITE_TIME_US 100

`endif

// >>> core/i2cew_pkg.sv
// types shared by the two-wire write-path slave
package i2cew_pkg;
    typedef enum logic [2:0] {
        I2CEW_IDLE = 3'b000,
        I2CEW_SEL = 3'b001,
        I2CEW_ADDR_HI = 3'b010,
        I2CEW_ADDR_LO = 3'b011,
        I2CEW_DATA = 3'b100,
        I2CEW_IGNORE = 3'b101,
        I2CEW_BUSY = 3'b110
    } i2cew_state_t;

    typedef struct packed {
        logic idpage;
        logic [16:0] addr;
        logic [7:0] data;
    } i2cew_beat_t;
endpackage

// >>> core/i2cew_slave.sv
// two-wire serial memory slave: select, address and write path
// Function
// - start on sda fall, scl high, unless busy
// - stop on sda rise, scl high, ends exchange
// - stop after read nack returns to standby
// - sample sda on rising scl
// - receiver pulls sda low on ninth clock
// - select code: type, straps, top bit, direction
// - respond only when strap bits match
// - direction bit one reads, zero writes
// - ack matching select, else release and standby
// - write: two acked address bytes, then data
// - address is top bit, high, low byte
// - write starts only on stop after data ack
// - counter holds next address after write
// - busy: sda released, requests ignored
// - write protect: data nacked, nothing written
// - page write takes up to 256 bytes
// - in-page address wraps to zero
// - in-page counter advances per buffered data byte
// - id page write: type 1011, lock bit zero
// - locked id page nacks its data bytes
// - lock command with data bit one locks until reset
// - write protect still acks select and address
// - busy leaves new select unacknowledged
`timescale 1ns/100ps
`include "i2cew_map.svh"
module i2cew_slave
    import i2cew_pkg::*;
#(
    parameter int WRITE_CYCLES = `I2CEW_WRITE_TIME_US * (`I2CEW_CLK_KHZ / 1000)
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_sel_strap_lo,
    input wire logic chip_sel_strap_hi,
    input wire logic write_protect_in,
    output i2cew_beat_t wr_beat,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic wr_commit,
    output logic wr_abort,
    output logic write_busy,
    output logic idpage_locked,
    output logic [16:0] addr_count
);
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(WRITE_CYCLES - 1);

    generate
        if (WRITE_CYCLES < 1) begin : g_bad
            $error("i2cew_slave: WRITE_CYCLES must be at least one");
        end
    endgenerate

    // =================================================================
    // line synchronisers and edge detection
    logic [2:0] scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_in};
            sda_q <= {sda_q[1:0], sda_in};
        end
    end

    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign start_det = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    assign stop_det = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

    // =================================================================
    // protocol state
    i2cew_state_t state_q, state_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic ack_ph_q, ack_ph_d, oe_q, oe_d;
    logic after_ack_q, after_ack_d, have_q, have_d;
    logic idp_q, idp_d, lock_q, lock_d, lock_pend_q, lock_pend_d;
    logic [16:0] addr_q, addr_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic commit_d, abort_d, commit_q, abort_q;
    logic busy_d, busy_q;
    i2cew_beat_t push_beat;
    logic push_valid, buf_ready;

    function automatic logic sel_match(input logic [7:0] b, input logic hi, input logic lo);
        sel_match = (b[`I2CEW_TYPE_MSB:`I2CEW_TYPE_LSB] == `I2CEW_TYPE_HEAD)
            && (b[`I2CEW_SEL_STRAP_HI] == hi) && (b[`I2CEW_SEL_STRAP_LO] == lo);
    endfunction

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ack_ph_d = ack_ph_q;
        oe_d = oe_q;
        after_ack_d = after_ack_q;
        have_d = have_q;
        idp_d = idp_q;
        lock_d = lock_q;
        lock_pend_d = lock_pend_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        commit_d = 1'h0;
        abort_d = 1'h0;
        push_valid = 1'h0;
        push_beat = '{idpage: idp_q, addr: addr_q, data: sh_q};
        if (state_q == I2CEW_BUSY) begin
            oe_d = 1'h0;
            if (cnt_q == '0) begin
                state_d = I2CEW_IDLE;
                lock_d = lock_q || lock_pend_q;
                lock_pend_d = 1'h0;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end else if (stop_det) begin
            oe_d = 1'h0;
            ack_ph_d = 1'h0;
            after_ack_d = 1'h0;
            have_d = 1'h0;
            if (state_q == I2CEW_DATA && after_ack_q && have_q) begin
                state_d = I2CEW_BUSY;
                cnt_d = LAST_CNT;
                commit_d = 1'h1;
            end else begin
                state_d = I2CEW_IDLE;
                abort_d = have_q;
                lock_pend_d = 1'h0;
            end
        end else if (start_det) begin
            state_d = I2CEW_SEL;
            bit_d = `I2CEW_BIT_RESET;
            oe_d = 1'h0;
            ack_ph_d = 1'h0;
            after_ack_d = 1'h0;
            abort_d = have_q;
            have_d = 1'h0;
            lock_pend_d = 1'h0;
        end else if (scl_fall && ack_ph_q) begin
            // ninth clock over in every state, read selects included
            oe_d = 1'h0;
            ack_ph_d = 1'h0;
            bit_d = `I2CEW_BIT_RESET;
            after_ack_d = (state_q == I2CEW_DATA) && oe_q;
        end else if (state_q != I2CEW_IDLE && state_q != I2CEW_IGNORE) begin
            if (scl_rise && !ack_ph_q) begin
                // the stop of the tenth slot rides on the first rise after an ack
                after_ack_d = after_ack_q && (bit_q == `I2CEW_BIT_RESET);
                sh_d = {sh_q[6:0], sda_q[2]};
                bit_d = bit_q + 4'h1;
            end else if (scl_fall && bit_q == `I2CEW_ACK_SLOT) begin
                ack_ph_d = 1'h1;
                unique case (state_q)
                    I2CEW_SEL: begin
                        if (sel_match(sh_q, chip_sel_strap_hi, chip_sel_strap_lo)) begin
                            oe_d = 1'h1;
                            idp_d = sh_q[`I2CEW_SEL_IDPAGE];
                            addr_d[16] = sh_q[`I2CEW_SEL_TOP_ADDR];
                            if (sh_q[`I2CEW_SEL_DIR] == `I2CEW_DIR_READ) begin
                                state_d = I2CEW_IGNORE;
                            end else begin
                                state_d = I2CEW_ADDR_HI;
                            end
                        end else begin
                            state_d = I2CEW_IDLE;
                        end
                    end
                    I2CEW_ADDR_HI: begin
                        oe_d = 1'h1;
                        addr_d[15:8] = sh_q;
                        state_d = I2CEW_ADDR_LO;
                    end
                    I2CEW_ADDR_LO: begin
                        oe_d = 1'h1;
                        addr_d[7:0] = sh_q;
                        state_d = I2CEW_DATA;
                    end
                    default: begin
                        if (idp_q && addr_q[`I2CEW_LOCK_SEL_BIT]) begin
                            if (!write_protect_in && !lock_q) begin
                                oe_d = 1'h1;
                                have_d = 1'h1;
                                lock_pend_d = lock_pend_q || sh_q[`I2CEW_LOCK_DATA_BIT];
                            end
                        end else if (!write_protect_in && !(idp_q && lock_q) && buf_ready) begin
                            oe_d = 1'h1;
                            have_d = 1'h1;
                            push_valid = 1'h1;
                            addr_d[7:0] = addr_q[7:0] + 8'h01;
                        end
                    end
                endcase
            end
        end
        busy_d = (state_d == I2CEW_BUSY);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= I2CEW_IDLE;
            bit_q <= `I2CEW_BIT_RESET;
            sh_q <= 8'h00;
            ack_ph_q <= 1'h0;
            oe_q <= 1'h0;
            after_ack_q <= 1'h0;
            have_q <= 1'h0;
            idp_q <= 1'h0;
            lock_q <= 1'h0;
            lock_pend_q <= 1'h0;
            addr_q <= `I2CEW_ADDR_RESET;
            cnt_q <= '0;
            commit_q <= 1'h0;
            abort_q <= 1'h0;
            busy_q <= 1'h0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ack_ph_q <= ack_ph_d;
            oe_q <= oe_d;
            after_ack_q <= after_ack_d;
            have_q <= have_d;
            idp_q <= idp_d;
            lock_q <= lock_d;
            lock_pend_q <= lock_pend_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            commit_q <= commit_d;
            abort_q <= abort_d;
            busy_q <= busy_d;
        end
    end

    // =================================================================
    // data buffer toward the memory port
    i2cew_buf2 #(
        .WIDTH($bits(i2cew_beat_t))
    ) u_buf (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_data(push_beat),
        .in_valid(push_valid),
        .in_ready(buf_ready),
        .out_data(wr_beat),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );

    assign sda_out = 1'h0;
    assign sda_oe = oe_q;
    assign wr_commit = commit_q;
    assign wr_abort = abort_q;
    assign write_busy = busy_q;
    assign idpage_locked = lock_q;
    assign addr_count = addr_q;

    // =================================================================
    // checks
    a_start_enters_sel: assert property (@(posedge core_clk) disable iff (!resetn)
        start_det && !stop_det && state_q != I2CEW_BUSY |=> state_q == I2CEW_SEL)
        else $error("start not taken");
    a_stop_to_idle: assert property (@(posedge core_clk) disable iff (!resetn)
        stop_det && state_q != I2CEW_BUSY && !commit_d |=> state_q == I2CEW_IDLE && !sda_oe)
        else $error("stop did not return to standby");
    a_busy_releases_sda: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_BUSY |-> !sda_oe && !push_valid)
        else $error("bus touched while busy");
    a_busy_no_select: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_BUSY && start_det |=> state_q != I2CEW_SEL)
        else $error("select seen while busy");
    a_commit_slot: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_d |-> after_ack_q && have_q && stop_det && state_q == I2CEW_DATA)
        else $error("write cycle started outside the tenth slot");
    a_busy_length: assert property (@(posedge core_clk) disable iff (!resetn)
        commit_q |-> write_busy && cnt_q == LAST_CNT)
        else $error("write cycle length wrong");
    a_wp_nacks_data: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_DATA && scl_fall && bit_q == `I2CEW_ACK_SLOT && !ack_ph_q
        && write_protect_in |-> !push_valid ##1 (!sda_oe && $stable(have_q)))
        else $error("protected data byte acknowledged");
    a_wp_acks_addr: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_ADDR_HI && scl_fall && bit_q == `I2CEW_ACK_SLOT && !ack_ph_q
        && !start_det && !stop_det |=> sda_oe ##0 state_q == I2CEW_ADDR_LO)
        else $error("address byte not acknowledged");
    a_page_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        push_valid |=> addr_q[16:8] == $past(addr_q[16:8])
        && addr_q[7:0] == $past(addr_q[7:0]) + 8'h01)
        else $error("in-page address did not advance inside the page");
    a_mismatch_release: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_SEL && scl_fall && bit_q == `I2CEW_ACK_SLOT && !ack_ph_q
        && !start_det && !stop_det
        && !sel_match(sh_q, chip_sel_strap_hi, chip_sel_strap_lo)
        |=> state_q == I2CEW_IDLE && !sda_oe)
        else $error("foreign select code answered");
    a_lock_sticks: assert property (@(posedge core_clk) disable iff (!resetn)
        idpage_locked |=> idpage_locked)
        else $error("identification page lock lost");
    a_locked_nack: assert property (@(posedge core_clk) disable iff (!resetn)
        lock_q && idp_q && state_q == I2CEW_DATA && scl_fall && !ack_ph_q
        && bit_q == `I2CEW_ACK_SLOT && !start_det && !stop_det |=> !sda_oe)
        else $error("locked page data acknowledged");
    a_ack_released: assert property (@(posedge core_clk) disable iff (!resetn)
        ack_ph_q && scl_fall |=> !sda_oe)
        else $error("acknowledge held past the ninth clock");
    a_select_acked: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_SEL && scl_fall && bit_q == `I2CEW_ACK_SLOT && !ack_ph_q
        && sel_match(sh_q, chip_sel_strap_hi, chip_sel_strap_lo)
        && sh_q[`I2CEW_SEL_DIR] != `I2CEW_DIR_READ |=> sda_oe && state_q == I2CEW_ADDR_HI)
        else $error("matching write select not acknowledged");
    a_read_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_SEL && scl_fall && bit_q == `I2CEW_ACK_SLOT && !ack_ph_q
        && sel_match(sh_q, chip_sel_strap_hi, chip_sel_strap_lo)
        && sh_q[`I2CEW_SEL_DIR] == `I2CEW_DIR_READ |=> sda_oe && state_q == I2CEW_IGNORE)
        else $error("read select not set aside");
    a_bit_sampled: assert property (@(posedge core_clk) disable iff (!resetn)
        scl_rise && !ack_ph_q && !start_det && !stop_det && state_q != I2CEW_BUSY
        && state_q != I2CEW_IDLE && state_q != I2CEW_IGNORE |=> sh_q[0] == $past(sda_q[2]))
        else $error("data bit not taken on the rising clock");
    a_busy_ends: assert property (@(posedge core_clk) disable iff (!resetn)
        write_busy && cnt_q == '0 |=> !write_busy)
        else $error("write cycle overran its count");
    a_tenth_commit: assert property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_DATA && after_ack_q && have_q && stop_det |=> wr_commit && write_busy)
        else $error("stop after a data ack did not start the write");

    c_write_commit: cover property (@(posedge core_clk) disable iff (!resetn) commit_q);
    c_page_wrap: cover property (@(posedge core_clk) disable iff (!resetn)
        push_valid && addr_q[7:0] == 8'hff);
    c_lock_set: cover property (@(posedge core_clk) disable iff (!resetn) $rose(idpage_locked));
    c_buffer_full: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_DATA && !buf_ready);
    c_read_select: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == I2CEW_IGNORE);
endmodule

// >>> tb/i2cew_master.sv
// two-wire bus master model that drives the slave under test
`timescale 1ns/100ps
module i2cew_master #(
    parameter int HALF = 5
) (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // =====================================================================
    // framing: sda moves with scl high only here
    task automatic start_cond();
        tick(1);
        sda_drv <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(1);
        sda_drv <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_drv <= 1'b1;
        tick(HALF);
    endtask

    // =====================================================================
    // one byte msb first, then released sda for the ninth clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(1);
            sda_drv <= b[i];
            tick(HALF);
            scl <= 1'b1;
            tick(HALF);
            scl <= 1'b0;
        end
        tick(1);
        sda_drv <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        ack = ~sda_line;
        scl <= 1'b0;
    endtask
endmodule

// >>> tb/i2cew_slave_tb.sv
// self-checking bench for the two-wire write-path slave
`timescale 1ns/100ps
module i2cew_slave_tb;
    localparam int WCYC = 400;
    typedef struct packed {
        logic hi, lo, wp;
        logic [7:0] sel, ah, al, d;
        logic sack, dack;
        logic [16:0] cnt;
    } i2cew_row_t;
    logic core_clk = 1'b0;
    logic resetn, scl, sda_drv, sda_oe, sda_out, wr_valid, wr_ready, wr_commit, wr_abort;
    logic chip_sel_strap_lo, chip_sel_strap_hi, write_protect_in, write_busy, idpage_locked;
    logic [16:0] addr_count;
    logic [25:0] wr_beat;
    logic [25:0] beats[$];
    int commits, aborts, busy_n, oe_bad, checked, fails;
    wire sda_line = sda_drv & ~(sda_oe & ~sda_out);
    i2cew_row_t rows [6] = '{
        '{1'h0, 1'h0, 1'h0, 8'ha0, 8'h01, 8'h02, 8'h5a, 1'h1, 1'h1, 17'h00103},
        '{1'h1, 1'h1, 1'h0, 8'hae, 8'h12, 8'hff, 8'h33, 1'h1, 1'h1, 17'h11200},
        '{1'h0, 1'h0, 1'h0, 8'ha4, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 17'h00000},
        '{1'h1, 1'h0, 1'h1, 8'ha8, 8'h00, 8'h40, 8'h66, 1'h1, 1'h0, 17'h00000},
        '{1'h0, 1'h0, 1'h0, 8'hb0, 8'h00, 8'h05, 8'h77, 1'h1, 1'h1, 17'h00006},
        '{1'h0, 1'h1, 1'h0, 8'ha6, 8'h00, 8'h00, 8'h11, 1'h1, 1'h1, 17'h10001}
    };

    i2cew_slave #(.WRITE_CYCLES(WCYC)) i2cew_slave_inst (
        .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_strap_lo(chip_sel_strap_lo),
        .chip_sel_strap_hi(chip_sel_strap_hi), .write_protect_in(write_protect_in),
        .wr_beat(wr_beat), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_commit(wr_commit),
        .wr_abort(wr_abort), .write_busy(write_busy), .idpage_locked(idpage_locked),
        .addr_count(addr_count));
    i2cew_master i2cew_master_inst (
        .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // =====================================================================
    // memory-side monitor
    always @(posedge core_clk) begin
        if (wr_valid && wr_ready) begin
            beats.push_back(wr_beat);
        end
        if (wr_commit) begin
            commits++;
        end
        if (wr_abort) begin
            aborts++;
        end
        if (write_busy) begin
            busy_n++;
        end
        if (write_busy && sda_oe) begin
            oe_bad++;
        end
    end

    // =====================================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        if (n == 2000) begin
            fails++;
            $display("Error write_busy expected 0 seen 1");
            wrap_up();
        end
        tick(4);
    endtask

    task automatic sb(input logic [7:0] b, input logic e);
        logic a;
        i2cew_master_inst.send_byte(b, a);
        check("ack", a, e);
    endtask

    task automatic take(input logic [25:0] exp);
        logic [25:0] got;
        got = 'x;
        if (beats.size() > 0) begin
            got = beats.pop_front();
        end
        check("beat", got, exp);
    endtask

    task automatic txn(input logic [7:0] sel, ah, al, d, input logic es, ed);
        i2cew_master_inst.start_cond();
        sb(sel, es);
        if (es) begin
            sb(ah, 1'b1);
            sb(al, 1'b1);
            sb(d, ed);
        end
        i2cew_master_inst.stop_cond();
    endtask

    // =====================================================================
    // main sequence
    initial begin
        int c0;
        int a0;
        resetn = 1'b0;
        chip_sel_strap_lo = 1'b0;
        chip_sel_strap_hi = 1'b0;
        write_protect_in = 1'b0;
        wr_ready = 1'b1;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        tick(4);
        check("sda_oe", sda_oe, 0);
        check("sda_out", sda_out, 0);
        check("wr_valid", wr_valid, 0);
        check("write_busy", write_busy, 0);
        check("idpage_locked", idpage_locked, 0);
        check("addr_count", addr_count, 0);
        foreach (rows[i]) begin
            chip_sel_strap_hi <= rows[i].hi;
            chip_sel_strap_lo <= rows[i].lo;
            write_protect_in <= rows[i].wp;
            c0 = commits;
            busy_n = 0;
            txn(rows[i].sel, rows[i].ah, rows[i].al, rows[i].d, rows[i].sack, rows[i].dack);
            wait_idle();
            check("commit", commits - c0, rows[i].dack);
            check("busy len", busy_n, rows[i].dack ? WCYC : 0);
            if (rows[i].dack) begin
                take({rows[i].sel[4], rows[i].sel[1], rows[i].ah, rows[i].al, rows[i].d});
                check("addr_count", addr_count, rows[i].cnt);
            end
        end
        chip_sel_strap_hi <= 1'b0;
        chip_sel_strap_lo <= 1'b0;
        write_protect_in <= 1'b0;
        // stalled memory side: third byte refused, page rolls over
        wr_ready <= 1'b0;
        c0 = commits;
        i2cew_master_inst.start_cond();
        sb(8'ha0, 1'b1);
        sb(8'h00, 1'b1);
        sb(8'hfe, 1'b1);
        sb(8'h01, 1'b1);
        sb(8'h02, 1'b1);
        check("held valid", wr_valid, 1);
        sb(8'h03, 1'b0);
        wr_ready <= 1'b1;
        sb(8'h04, 1'b1);
        i2cew_master_inst.stop_cond();
        txn(8'ha0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        wait_idle();
        check("commit", commits - c0, 1);
        take({1'b0, 17'h000fe, 8'h01});
        take({1'b0, 17'h000ff, 8'h02});
        take({1'b0, 17'h00000, 8'h04});
        check("addr_count", addr_count, 17'h00001);
        // stop after address, then start after a data ack
        c0 = commits;
        a0 = aborts;
        i2cew_master_inst.start_cond();
        sb(8'ha0, 1'b1);
        sb(8'h00, 1'b1);
        sb(8'h10, 1'b1);
        i2cew_master_inst.stop_cond();
        i2cew_master_inst.start_cond();
        sb(8'ha0, 1'b1);
        sb(8'h00, 1'b1);
        sb(8'h20, 1'b1);
        sb(8'h11, 1'b1);
        i2cew_master_inst.start_cond();
        sb(8'ha1, 1'b1);
        i2cew_master_inst.stop_cond();
        tick(8);
        check("commit", commits - c0, 0);
        check("abort", aborts - a0, 1);
        take({1'b0, 17'h00020, 8'h11});
        // lock until reset, then a refused identification write
        c0 = commits;
        txn(8'hb0, 8'h04, 8'h00, 8'h02, 1'b1, 1'b1);
        wait_idle();
        check("commit", commits - c0, 1);
        check("idpage_locked", idpage_locked, 1);
        txn(8'hb0, 8'h00, 8'h01, 8'h55, 1'b1, 1'b0);
        wait_idle();
        check("beats left", beats.size(), 0);
        check("oe while busy", oe_bad, 0);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(4);
        check("idpage_locked", idpage_locked, 0);
        wrap_up();
    end
endmodule
